//--- rtl/rsqm_regs.vh
// Register offsets, fields, reset values and constants of the qualifier block
`ifndef RSQM_REGS_VH
`define RSQM_REGS_VH
`define RSQM_ADDR_W 8
`define RSQM_OFF_FREQ_DEV 8'h00
`define RSQM_OFF_MODEM_B 8'h04
`define RSQM_OFF_PKT_CTRL_B 8'h08
`define RSQM_OFF_PIN_FUNC 8'h0C
`define RSQM_OFF_GAIN_C 8'h10
`define RSQM_OFF_PKT_STATE 8'h14
`define RSQM_OFF_RSSI 8'h18
`define RSQM_OFF_DEV_STEP 8'h1C
`define RSQM_RST_FREQ_DEV 8'h47
`define RSQM_RST_MODEM_B 8'h03
`define RSQM_RST_PKT_CTRL_B 8'h04
`define RSQM_RST_PIN_FUNC 8'h00
`define RSQM_RST_GAIN_C 8'h00
`define RSQM_DEVM_LSB 0
`define RSQM_DEVE_LSB 4
`define RSQM_SYNC_LSB 0
`define RSQM_MANCH_BIT 3
`define RSQM_MOD_LSB 4
`define RSQM_APPEND_BIT 2
`define RSQM_PQT_LSB 5
`define RSQM_FLEN_LSB 0
`define RSQM_MOD_2FSK 3'h0
`define RSQM_MOD_GFSK 3'h1
`define RSQM_MOD_MSK 3'h7
`define RSQM_PIN_PQT_HIT 4'h8
`define RSQM_PIN_CS 4'hE
`define RSQM_PQ_DEC 8'h08
`define RSQM_DEV_BASE 17'h00008
`endif

//--- rtl/rsqm_rssi_store.v
// Signal strength store with freeze at sync and append capture
`timescale 1ns/1ps
module rsqm_rssi_store (
  input wire clk,
  input wire rst,
  input wire rx_entry,
  input wire rx_active,
  input wire sample_valid,
  input wire [7:0] sample,
  input wire sync_hit,
  output reg [7:0] rssi_value,
  output reg [7:0] append_value,
  output reg frozen
);
  always @(posedge clk)
  begin
    if (rst)
    begin
      rssi_value <= 8'h80;
      append_value <= 8'h80;
      frozen <= 1'b0;
    end
    else
    begin
      if (rx_entry)
        frozen <= 1'b0; // [RULE_16]
      else if (sync_hit)
        frozen <= 1'b1; // [RULE_16]
      // Sample taken at the sync edge itself is the appended value
      if (sync_hit && !frozen)
        append_value <= sample_valid ? sample : rssi_value; // [RULE_18]
      if (rx_active && sample_valid && (!frozen || rx_entry) && !sync_hit)
        rssi_value <= sample; // [RULE_16] [RULE_19]
      else if (rx_active && sample_valid && sync_hit && !frozen)
        rssi_value <= sample;
    end
  end
endmodule // rsqm_rssi_store

//--- rtl/rsqm_top.v
// Modulation settings, sync qualifier and preamble quality logic
// Behaviour
// [RULE_01] Format select GFSK applies Gaussian BT=1 shaping to 2-FSK symbols.
// [RULE_02] Deviation step is (8+mantissa) shifted by exponent, over 2^17 fref.
// [RULE_03] FSK symbol 0 drives negative deviation, 1 positive deviation.
// [RULE_04] Software should program receive deviation equal to transmit one.
// [RULE_05] MSK selection modulates preamble, sync word and payload alike.
// [RULE_06] MSK phase transitions all take the same fixed time.
// [RULE_07] MSK transmits sync and data bits inverted.
// [RULE_08] MSK ignores deviation in receive; Manchester must stay off.
// [RULE_09] With sync search on, no byte output or filtering before sync.
// [RULE_10] Sync mode 000 none, 001 15/16, 010 16/16, 011 30/32 bits.
// [RULE_11] Modes 100 to 111 repeat those, also needing carrier sense.
// [RULE_12] With quality qualifier on, sync accepted only above threshold.
// [RULE_13] Quality counter plus one per transition, minus eight per repeat.
// [RULE_14] Gate at counter reaching four times threshold; zero disables.
// [RULE_15] Quality hit shown in status bit and on pin with code 1000.
// [RULE_16] Signal strength updates in receive until sync, then holds.
// [RULE_17] Strength sample rate is 2*BW over 8*2^filter length.
// [RULE_18] With append on, sync-time strength is the first status byte.
// [RULE_19] Strength register holds two's complement half-dB value.
// [RULE_20] Software converts raw strength to dBm with sign and offset.
// [RULE_21] Modulation field and Manchester enable sit in modem config.
// [RULE_22] Quality counter saturates at zero, clears on receive entry.
// [RULE_23] Carrier sense sampled in the cycle correlation is judged.
`timescale 1ns/1ps
`include "rsqm_regs.vh"
module rsqm_top (
  input wire CLK,
  input wire RST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output wire PREADY,
  output reg [31:0] PRDATA,
  output wire PSLVERR,
  input wire RX_ACTIVE,
  input wire RX_BIT_VALID,
  input wire RX_BIT,
  input wire [31:0] SYNC_CORR_ERRORS,
  input wire CARRIER_SENSE,
  input wire [7:0] RX_BYTE,
  input wire RX_BYTE_VALID,
  input wire RSSI_STROBE,
  input wire [7:0] RSSI_SAMPLE,
  input wire TX_BIT_VALID,
  input wire TX_BIT,
  input wire TX_IN_PREAMBLE,
  output reg TX_SYMBOL,
  output reg TX_SYMBOL_VALID,
  output reg TX_GAUSS_EN,
  output reg TX_MSK_EN,
  output reg RX_DEV_USE,
  output reg MANCH_EN,
  output reg [16:0] DEV_STEP,
  output reg SYNC_FOUND,
  output reg [7:0] RX_DATA,
  output reg RX_DATA_VALID,
  output reg FILTER_EN,
  output reg [7:0] APPEND_RSSI,
  output reg APPEND_EN,
  output reg [2:0] RSSI_FILTER_LEN,
  output reg GP_OUT
);
  reg [7:0] freq_dev_config;
  reg [7:0] modem_config_b;
  reg [7:0] packet_control_b;
  reg [7:0] pin_function_config;
  reg [7:0] gain_control_c;
  reg [7:0] pq_count;
  reg prev_bit;
  reg have_prev;
  reg rx_active_d;
  reg sync_seen;
  reg preamble_quality_hit;
  reg [7:0] next_pq_count;
  reg sync_ok;
  wire rx_entry;
  wire [2:0] modulation_sel;
  wire [2:0] sync_mode;
  wire [2:0] preamble_quality_threshold;
  wire [3:0] pin_output_select;
  wire [7:0] pq_limit;
  wire pq_gate;
  wire sync_hit;
  wire [7:0] rssi_value;
  wire [7:0] append_value;
  wire rssi_frozen;
  wire [7:0] packet_state_flags;
  wire wr_en;
  wire rd_en;
  wire sync_search;
  wire pq_enabled;

  // Match criteria of the low two sync mode bits
  localparam [1:0] SYNC_NONE = 2'b00;
  localparam [1:0] SYNC_15OF16 = 2'b01;
  localparam [1:0] SYNC_16OF16 = 2'b10;
  localparam [1:0] SYNC_30OF32 = 2'b11;

  // Decodes one register select, shared by read and write paths
  function sel_hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      sel_hit = (addr == off);
    end
  endfunction

  // Every access answers in its first access cycle
  assign PREADY = 1'b1;
  assign PSLVERR = 1'b0;
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_en = PSEL && !PENABLE && !PWRITE;

  assign modulation_sel = modem_config_b[`RSQM_MOD_LSB +: 3]; // [RULE_21]
  assign sync_mode = modem_config_b[`RSQM_SYNC_LSB +: 3];
  assign preamble_quality_threshold =
    packet_control_b[`RSQM_PQT_LSB +: 3];
  assign pin_output_select = pin_function_config[3:0];
  assign rx_entry = RX_ACTIVE && !rx_active_d;
  assign sync_search = sync_mode[1:0] != SYNC_NONE;
  assign pq_enabled = preamble_quality_threshold != 3'h0;

  // Byte wide settings; upper write data bits are dropped
  always @(posedge CLK)
  begin
    if (RST)
    begin
      freq_dev_config <= `RSQM_RST_FREQ_DEV;
      modem_config_b <= `RSQM_RST_MODEM_B;
      packet_control_b <= `RSQM_RST_PKT_CTRL_B;
      pin_function_config <= `RSQM_RST_PIN_FUNC;
      gain_control_c <= `RSQM_RST_GAIN_C;
    end
    else if (wr_en)
    begin
      if (sel_hit(PADDR, `RSQM_OFF_FREQ_DEV))
        freq_dev_config <= PWDATA[7:0];
      if (sel_hit(PADDR, `RSQM_OFF_MODEM_B))
        modem_config_b <= PWDATA[7:0];
      if (sel_hit(PADDR, `RSQM_OFF_PKT_CTRL_B))
        packet_control_b <= PWDATA[7:0];
      if (sel_hit(PADDR, `RSQM_OFF_PIN_FUNC))
        pin_function_config <= PWDATA[7:0];
      if (sel_hit(PADDR, `RSQM_OFF_GAIN_C))
        gain_control_c <= PWDATA[7:0];
    end
  end

  // Status word is live; it is sampled only when a read is set up
  assign packet_state_flags = {2'b00, sync_seen, preamble_quality_hit,
    rssi_frozen, CARRIER_SENSE, RX_ACTIVE, pq_gate}; // [RULE_15]

  // Read data registered in setup so it is stable in the access phase
  always @(posedge CLK)
  begin
    if (RST)
      PRDATA <= 32'h00000000;
    else if (rd_en)
    begin
      PRDATA <= 32'h00000000;
      if (sel_hit(PADDR, `RSQM_OFF_FREQ_DEV))
        PRDATA[7:0] <= freq_dev_config;
      if (sel_hit(PADDR, `RSQM_OFF_MODEM_B))
        PRDATA[7:0] <= modem_config_b;
      if (sel_hit(PADDR, `RSQM_OFF_PKT_CTRL_B))
        PRDATA[7:0] <= packet_control_b;
      if (sel_hit(PADDR, `RSQM_OFF_PIN_FUNC))
        PRDATA[7:0] <= pin_function_config;
      if (sel_hit(PADDR, `RSQM_OFF_GAIN_C))
        PRDATA[7:0] <= gain_control_c;
      if (sel_hit(PADDR, `RSQM_OFF_PKT_STATE))
        PRDATA[7:0] <= packet_state_flags;
      if (sel_hit(PADDR, `RSQM_OFF_RSSI))
        PRDATA[7:0] <= rssi_value; // [RULE_19]
      if (sel_hit(PADDR, `RSQM_OFF_DEV_STEP))
        PRDATA[16:0] <= DEV_STEP;
    end
  end

  // Preamble quality estimator
  always @*
  begin
    next_pq_count = pq_count;
    if (RX_BIT_VALID && have_prev)
    begin
      if (RX_BIT != prev_bit)
        next_pq_count = (pq_count == 8'hFF) ? pq_count :
          pq_count + 8'h01; // [RULE_13]
      else if (pq_count < `RSQM_PQ_DEC)
        next_pq_count = 8'h00; // [RULE_22]
      else
        next_pq_count = pq_count - `RSQM_PQ_DEC; // [RULE_13]
    end
  end

  assign pq_limit = {3'b000, preamble_quality_threshold, 2'b00};
  assign pq_gate = !pq_enabled ||
    (pq_count >= pq_limit); // [RULE_14]

  always @(posedge CLK)
  begin
    if (RST || rx_entry)
    begin
      pq_count <= 8'h00; // [RULE_22]
      have_prev <= 1'b0;
      prev_bit <= 1'b0;
      preamble_quality_hit <= 1'b0;
    end
    else
    begin
      pq_count <= next_pq_count;
      if (RX_BIT_VALID)
      begin
        prev_bit <= RX_BIT;
        have_prev <= 1'b1;
      end
      // Strictly above the gate level, so the hit may lag the gate a bit
      preamble_quality_hit <= pq_enabled &&
        (next_pq_count > pq_limit); // [RULE_15]
    end
  end

  // Correlation and carrier sense judged together in this cycle
  always @*
  begin
    case (sync_mode[1:0])
      SYNC_NONE: sync_ok = 1'b0; // [RULE_10]
      SYNC_15OF16: sync_ok = SYNC_CORR_ERRORS[15:0] != 16'h0000 &&
        (SYNC_CORR_ERRORS[15:0] & (SYNC_CORR_ERRORS[15:0] - 16'h0001))
        == 16'h0000 || SYNC_CORR_ERRORS[15:0] == 16'h0000; // [RULE_10]
      SYNC_16OF16: sync_ok = SYNC_CORR_ERRORS[15:0] == 16'h0000; // [RULE_10]
      SYNC_30OF32: sync_ok = ones32(SYNC_CORR_ERRORS) <= 6'd2; // [RULE_10]
      default: sync_ok = 1'b0;
    endcase
  end

  // Counts mismatching bits of the doubled word
  function [5:0] ones32;
    input [31:0] v;
    integer i;
    begin
      ones32 = 6'd0;
      for (i = 0; i < 32; i = i + 1)
        ones32 = ones32 + {5'd0, v[i]};
    end
  endfunction

  // Entry cycle still sees the last reception's quality, so it is skipped
  assign sync_hit = RX_ACTIVE && RX_BIT_VALID && !sync_seen && sync_ok &&
    !rx_entry &&
    (!sync_mode[2] || CARRIER_SENSE) && // [RULE_11] [RULE_23]
    pq_gate; // [RULE_12]

  always @(posedge CLK)
  begin
    if (RST || rx_entry)
    begin
      rx_active_d <= RST ? 1'b0 : RX_ACTIVE;
      sync_seen <= 1'b0;
      SYNC_FOUND <= 1'b0;
      RX_DATA <= 8'h00;
      RX_DATA_VALID <= 1'b0;
      FILTER_EN <= 1'b0;
    end
    else
    begin
      rx_active_d <= RX_ACTIVE;
      SYNC_FOUND <= sync_hit;
      if (sync_hit)
        sync_seen <= 1'b1;
      // No search mode passes bytes without waiting for sync
      RX_DATA_VALID <= RX_BYTE_VALID &&
        (sync_seen || !sync_search); // [RULE_09]
      FILTER_EN <= RX_ACTIVE &&
        (sync_seen || !sync_search); // [RULE_09]
      if (RX_BYTE_VALID)
        RX_DATA <= RX_BYTE;
    end
  end

  // Store freezes on the same sync pulse that raises SYNC_FOUND
  rsqm_rssi_store rsqm_rssi_store_i (
    .clk(CLK),
    .rst(RST),
    .rx_entry(rx_entry),
    .rx_active(RX_ACTIVE),
    .sample_valid(RSSI_STROBE), // [RULE_17]
    .sample(RSSI_SAMPLE),
    .sync_hit(sync_hit),
    .rssi_value(rssi_value),
    .append_value(append_value),
    .frozen(rssi_frozen)
  );

  // Modulator settings and symbol mapping
  always @(posedge CLK)
  begin
    if (RST)
    begin
      TX_SYMBOL <= 1'b0;
      TX_SYMBOL_VALID <= 1'b0;
      TX_GAUSS_EN <= 1'b0;
      TX_MSK_EN <= 1'b0;
      RX_DEV_USE <= 1'b1;
      MANCH_EN <= 1'b0;
      DEV_STEP <= 17'h00000;
      APPEND_RSSI <= 8'h00;
      APPEND_EN <= 1'b0;
      RSSI_FILTER_LEN <= 3'h0;
      GP_OUT <= 1'b0;
    end
    else
    begin
      TX_GAUSS_EN <= modulation_sel == `RSQM_MOD_GFSK; // [RULE_01]
      // Preamble keeps its polarity, only sync word and data invert
      TX_MSK_EN <= modulation_sel == `RSQM_MOD_MSK; // [RULE_05] [RULE_06]
      RX_DEV_USE <= modulation_sel != `RSQM_MOD_MSK; // [RULE_08]
      // Manchester forced off under MSK to protect the link
      MANCH_EN <= modem_config_b[`RSQM_MANCH_BIT] &&
        modulation_sel != `RSQM_MOD_MSK; // [RULE_08] [RULE_21]
      TX_SYMBOL_VALID <= TX_BIT_VALID;
      if (TX_BIT_VALID)
        TX_SYMBOL <= (modulation_sel == `RSQM_MOD_MSK && !TX_IN_PREAMBLE)
          ? !TX_BIT : TX_BIT; // [RULE_03] [RULE_07]
      // Largest step, fifteen shifted by seven, still fits 17 bits
      DEV_STEP <= (`RSQM_DEV_BASE + {14'h0000,
        freq_dev_config[`RSQM_DEVM_LSB +: 3]})
        << freq_dev_config[`RSQM_DEVE_LSB +: 3]; // [RULE_02]
      APPEND_EN <= packet_control_b[`RSQM_APPEND_BIT];
      APPEND_RSSI <= append_value; // [RULE_18]
      RSSI_FILTER_LEN <= gain_control_c[`RSQM_FLEN_LSB +: 3]; // [RULE_17]
      case (pin_output_select)
        `RSQM_PIN_PQT_HIT: GP_OUT <= preamble_quality_hit; // [RULE_15]
        `RSQM_PIN_CS: GP_OUT <= CARRIER_SENSE;
        default: GP_OUT <= 1'b0;
      endcase
    end
  end
endmodule // rsqm_top

//--- tb/rsqm_chk.sv
// Port-level assertions for the qualifier block
`timescale 1ns/1ps
module rsqm_chk (
  input wire CLK,
  input wire RST,
  input wire RX_BIT_VALID,
  input wire RX_BYTE_VALID,
  input wire TX_BIT_VALID,
  input wire TX_BIT,
  input wire TX_IN_PREAMBLE,
  input wire TX_SYMBOL,
  input wire TX_SYMBOL_VALID,
  input wire TX_GAUSS_EN,
  input wire TX_MSK_EN,
  input wire RX_DEV_USE,
  input wire SYNC_FOUND,
  input wire RX_DATA_VALID,
  input wire [7:0] APPEND_RSSI
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  sym_timing_a: assert property (
    TX_BIT_VALID |=> TX_SYMBOL_VALID) else $error("late symbol");
  fsk_polarity_a: assert property (
    TX_BIT_VALID && !TX_MSK_EN |=> TX_SYMBOL == $past(TX_BIT))
    else $error("fsk symbol polarity");
  msk_invert_a: assert property (
    TX_BIT_VALID && TX_MSK_EN |=>
    TX_SYMBOL == ($past(TX_BIT) ~^ $past(TX_IN_PREAMBLE)))
    else $error("msk symbol polarity");
  dev_ignore_a: assert property (
    RX_DEV_USE == !TX_MSK_EN) else $error("deviation use under msk");
  gauss_only_a: assert property (
    TX_GAUSS_EN |-> !TX_MSK_EN) else $error("shaping with msk");
  sync_cause_a: assert property (
    SYNC_FOUND |-> $past(RX_BIT_VALID))
    else $error("sync without bit");
  data_gate_a: assert property (
    RX_DATA_VALID |-> $past(RX_BYTE_VALID))
    else $error("data without byte");
  append_hold_a: assert property (
    $changed(APPEND_RSSI) && !$past(RST, 2) |-> $past(SYNC_FOUND))
    else $error("append value moved");
  cover property (SYNC_FOUND);
  cover property (RX_DATA_VALID);
  cover property (TX_SYMBOL_VALID && TX_MSK_EN);
endmodule // rsqm_chk
bind rsqm_top rsqm_chk rsqm_chk_i (.*);

//--- tb/rsqm_top_tb.sv
// Self-checking bench for the qualifier block
`timescale 1ns/1ps
module rsqm_top_tb;
  logic CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [7:0] PADDR = 0, RX_BYTE = 0, RSSI_SAMPLE = 0;
  logic [31:0] PWDATA = 0, SYNC_CORR_ERRORS = 0;
  logic RX_ACTIVE = 0, RX_BIT_VALID = 0, RX_BIT = 0, CARRIER_SENSE = 0;
  logic RX_BYTE_VALID = 0, RSSI_STROBE = 0, TX_BIT_VALID = 0, TX_BIT = 0;
  logic TX_IN_PREAMBLE = 0;
  wire PREADY, PSLVERR, TX_SYMBOL, TX_SYMBOL_VALID, TX_GAUSS_EN, TX_MSK_EN;
  wire RX_DEV_USE, MANCH_EN, SYNC_FOUND, RX_DATA_VALID, FILTER_EN;
  wire APPEND_EN, GP_OUT;
  wire [31:0] PRDATA;
  wire [16:0] DEV_STEP;
  wire [7:0] RX_DATA, APPEND_RSSI;
  wire [2:0] RSSI_FILTER_LEN;
  int n_mismatch = 0, tests_run = 0, cyc = 0;
  // Random source starts at 91726
  logic [31:0] rd, rs = 32'h0001664E;
  logic [7:0] v;
  logic sf, dv;
  logic [31:0] masks [0:4] = '{32'h0, 32'h1, 32'h00010001, 32'h3,
    32'h00030001};
  logic [7:0] rv [0:4] = '{8'h47, 8'h03, 8'h04, 8'h00, 8'h00};
  logic [2:0] mods [0:2] = '{3'h0, 3'h1, 3'h7};

  rsqm_top rsqm_top_i (.*);

  function logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? (s >> 1) ^ 32'hA3000001 : s >> 1;
  endfunction

  function logic exp_sync(input logic [2:0] m, input logic [31:0] e,
    input logic c);
    int n16;
    int n32;
    n16 = $countones(e[15:0]);
    n32 = $countones(e);
    exp_sync = 0;
    if (m[1:0] == 2'h1)
      exp_sync = n16 <= 1;
    if (m[1:0] == 2'h2)
      exp_sync = n16 == 0;
    if (m[1:0] == 2'h3)
      exp_sync = n32 <= 2;
    if (m[2] && !c)
      exp_sync = 0;
  endfunction

  task give_verdict;
    if (n_mismatch == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1;
    @(posedge CLK);
    while (PREADY !== 1'b1)
      @(posedge CLK);
    rd = PRDATA;
    PSEL <= 0;
    PENABLE <= 0;
    @(posedge CLK);
    // Config outputs are registered once more after the write lands
    if (w)
      @(posedge CLK);
  endtask

  // Outputs may land one or two edges late, so both are watched
  task rbit(input logic b, input logic [31:0] e, input logic c);
    RX_BIT_VALID <= 1;
    RX_BIT <= b;
    SYNC_CORR_ERRORS <= e;
    CARRIER_SENSE <= c;
    @(posedge CLK);
    RX_BIT_VALID <= 0;
    sf = SYNC_FOUND;
    @(posedge CLK);
    sf = sf | SYNC_FOUND;
  endtask

  task rbyte(input logic [7:0] b);
    RX_BYTE <= b;
    RX_BYTE_VALID <= 1;
    @(posedge CLK);
    RX_BYTE_VALID <= 0;
    dv = RX_DATA_VALID;
    @(posedge CLK);
    dv = dv | RX_DATA_VALID;
  endtask

  task strobe(input logic [7:0] b);
    RSSI_SAMPLE <= b;
    RSSI_STROBE <= 1;
    @(posedge CLK);
    RSSI_STROBE <= 0;
    @(posedge CLK);
  endtask

  task tx(input logic b, input logic p);
    TX_BIT_VALID <= 1;
    TX_BIT <= b;
    TX_IN_PREAMBLE <= p;
    @(posedge CLK);
    TX_BIT_VALID <= 0;
    @(posedge CLK);
  endtask

  task rx_in;
    RX_ACTIVE <= 0;
    @(posedge CLK);
    RX_ACTIVE <= 1;
    @(posedge CLK);
  endtask

  initial
  begin
    forever #5 CLK = ~CLK;
  end

  always @(posedge CLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial
  begin
    repeat (8) @(posedge CLK);
    RST <= 0;
    @(posedge CLK);
    for (int i = 0; i < 5; i++)
    begin
      apb(0, 8'(i * 4), 0);
      chk(rd, {24'h0, rv[i]});
    end
    apb(0, 8'h18, 0);
    chk(rd, 32'h80);
    apb(1, 8'h20, 32'hFF);
    apb(0, 8'h20, 0);
    chk(rd, 0);
    chk(PSLVERR, 0);
    for (int i = 0; i < 5; i++)
    begin
      rs = lfsr(rs);
      v = i ? rs[7:0] : 8'h77;
      apb(1, 8'h00, {24'h0, v});
      chk(DEV_STEP, (32'h8 + v[2:0]) << v[6:4]);
      apb(0, 8'h1C, 0);
      chk(rd, (32'h8 + v[2:0]) << v[6:4]);
    end
    foreach (mods[k])
    begin
      apb(1, 8'h04, {25'h0, mods[k], mods[k] != 3'h7, 3'h2});
      chk(TX_GAUSS_EN, mods[k] == 3'h1);
      chk(TX_MSK_EN, mods[k] == 3'h7);
      chk(RX_DEV_USE, mods[k] != 3'h7);
      chk(MANCH_EN, mods[k] != 3'h7);
      repeat (4)
      begin
        rs = lfsr(rs);
        tx(rs[0], rs[1]);
        chk(TX_SYMBOL, rs[0] ^ (mods[k] == 3'h7 && !rs[1]));
      end
    end
    apb(1, 8'h08, 32'h0);
    chk(APPEND_EN, 0);
    apb(1, 8'h08, 32'h4);
    chk(APPEND_EN, 1);
    for (int m = 0; m < 8; m++)
    begin
      apb(1, 8'h04, 32'(m));
      foreach (masks[j])
      begin
        rs = lfsr(rs);
        rx_in();
        rbit(rs[0], masks[j], rs[1]);
        chk(sf, exp_sync(3'(m), masks[j], rs[1]));
      end
    end
    apb(1, 8'h04, 32'h2);
    apb(1, 8'h10, 32'h5);
    chk(RSSI_FILTER_LEN, 5);
    rx_in();
    strobe(8'hC3);
    apb(0, 8'h18, 0);
    chk(rd, 32'hC3);
    rbyte(8'h5A);
    chk(dv, 0);
    chk(FILTER_EN, 0);
    rbit(1, 0, 0);
    chk(sf, 1);
    strobe(8'h21);
    apb(0, 8'h18, 0);
    chk(rd, 32'hC3);
    chk(APPEND_RSSI, 8'hC3);
    rbyte(8'h5A);
    chk(dv, 1);
    chk(RX_DATA, 8'h5A);
    chk(FILTER_EN, 1);
    rx_in();
    strobe(8'h21);
    apb(0, 8'h18, 0);
    chk(rd, 32'h21);
    apb(1, 8'h08, 32'h24);
    apb(1, 8'h0C, 32'h8);
    for (int p = 0; p < 2; p++)
    begin
      rx_in();
      // Quality hit reaches the pin through two register stages
      repeat (2) @(posedge CLK);
      chk(GP_OUT, 0);
      rbit(0, 0, 1);
      chk(sf, 0);
      for (int i = 0; i < 8; i++)
        rbit(!i[0], 32'hFFFFFFFF, 1);
      if (p)
        repeat (2) rbit(0, 32'hFFFFFFFF, 1);
      chk(GP_OUT, !p);
      apb(0, 8'h14, 0);
      chk(rd, p ? 32'h06 : 32'h17);
      rbit(1, 0, 1);
      chk(sf, !p);
    end
    apb(1, 8'h0C, 32'hE);
    chk(GP_OUT, 1);
    CARRIER_SENSE <= 0;
    repeat (2) @(posedge CLK);
    chk(GP_OUT, 0);
    give_verdict();
  end
endmodule // rsqm_top_tb
